// >>> shared/bad_pkg.sv
// How it works
// - mode 0 shows only low 32kB RAM up to 0x7FFF, network at 0x8000-0x9000.
// - banking mode maps base RAM to 0x7FFF and chosen 16kB bank at 0x8000-0xBFFF.
// - host writes bank number to 0xFF00; window accesses go to that bank.
// - banking mode base area is always backed by the last RAM banks.
// - banking mode places the network register area at 0xC000.
// - linear mode maps RAM from zero to 0xFEFF, network at 0xFF80.
// - two user outputs, each a write strobe, read strobe or select, either polarity.
// - 0xFF00-0xFFFF is kept for registers, user output areas and network area.
// - bank number steers mapping only in map mode 1.
// - bank register keeps four low bits; bits 4-7 read zero, writes dropped.
// - configuration register at 0xFF01 sets map mode and both user outputs.
// - configuration bits 1:0 are the map mode.
// - bits 6:5 are output b mode, bit 7 its polarity, zero active low.
// - bits 3:2 are output a mode, bit 4 its polarity, zero active low.
// - configuration register is write-only; reads give no usable value.
// - map mode 00 compatibility, 01 banking, 10 maximum linear.
// - output mode 00 write pulse, 01 read pulse, 10 any access, 11 static.
// - output a answers 0xFF04-0xFF07, output b answers 0xFF08-0xFF0B.
// - output b in mode 11 follows bank bit 3, the top RAM address bit.
package bad_pkg;

  // ==========================================================
  // widths
  localparam int BUS_ADDR_W = 16;
  localparam int BUS_DATA_W = 8;
  localparam int BANK_W     = 4;
  localparam int RAM_ADDR_W = 18;
  localparam int NET_ADDR_W = 12;

  // ==========================================================
  // register addresses and reset values
  localparam logic [15:0] ADDR_BANK_CHOICE = 16'hFF00;
  localparam logic [15:0] ADDR_DEC_CONFIG  = 16'hFF01;
  localparam logic [7:0]  CONF_RESET       = 8'h00;
  localparam logic [3:0]  BANK_RESET       = 4'h0;

  // ==========================================================
  // address map boundaries
  localparam logic [15:0] LOW_RAM_TOP  = 16'h7FFF;
  localparam logic [15:0] WINDOW_BASE  = 16'h8000;
  localparam logic [15:0] WINDOW_TOP   = 16'hBFFF;
  localparam logic [15:0] NET_M0_BASE  = 16'h8000;
  localparam logic [15:0] NET_M0_TOP   = 16'h9000;
  localparam logic [15:0] NET_M1_BASE  = 16'hC000;
  localparam logic [15:0] NET_M1_TOP   = 16'hCFFF;
  localparam logic [15:0] LINEAR_TOP   = 16'hFEFF;
  localparam logic [15:0] NET_M2_BASE  = 16'hFF80;
  localparam logic [15:0] RESERVED_BASE = 16'hFF00;
  localparam logic [15:0] UOA_BASE     = 16'hFF04;
  localparam logic [15:0] UOB_BASE     = 16'hFF08;

  // ==========================================================
  // types
  typedef enum logic [1:0] {
    MAP_COMPAT  = 2'h0,
    MAP_BANKED  = 2'h1,
    MAP_LINEAR  = 2'h2,
    MAP_SPARE   = 2'h3
  } bad_map_mode_t;

  typedef enum logic [1:0] {
    UO_WR_STROBE = 2'h0,
    UO_RD_STROBE = 2'h1,
    UO_SELECT    = 2'h2,
    UO_STATIC    = 2'h3
  } bad_uo_mode_t;

  typedef struct packed {
    logic         polarity;
    bad_uo_mode_t mode;
  } bad_uo_cfg_t;

  // bit 7 polarity b, 6:5 mode b, 4 polarity a, 3:2 mode a, 1:0 map mode
  typedef struct packed {
    bad_uo_cfg_t   outB;
    bad_uo_cfg_t   outA;
    bad_map_mode_t mapMode;
  } bad_dec_cfg_t;

  // one host bus request as seen in a clock cycle
  typedef struct packed {
    logic [15:0] addr;
    logic        wr;
    logic        rd;
    logic [7:0]  wrData;
  } bad_bus_req_t;

endpackage

// >>> design/bad_user_output.sv
`timescale 1ns/10ps
// ==========================================================
// one user output: strobe, select or static level
module bad_user_output (
  clk,
  sys_rst,
  hit,
  wr,
  rd,
  cfg,
  staticLevel,
  userOut
);
  input  wire logic             clk;
  input  wire logic             sys_rst;
  input  wire logic             hit;
  input  wire logic             wr;
  input  wire logic             rd;
  input  wire bad_pkg::bad_uo_cfg_t cfg;
  input  wire logic             staticLevel;
  output logic                  userOut;

  logic active;

  // pick the access kinds that assert the output
  always_comb begin
    unique case (cfg.mode)
      bad_pkg::UO_WR_STROBE: active = hit & wr;
      bad_pkg::UO_RD_STROBE: active = hit & rd;
      bad_pkg::UO_SELECT:    active = hit & (wr | rd);
      bad_pkg::UO_STATIC:    active = 1'b0;
    endcase
  end

  // registered level; idles at the inverse of the polarity bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      userOut <= 1'b1; // inactive for the reset polarity (active low)
    end else if (cfg.mode == bad_pkg::UO_STATIC) begin
      userOut <= staticLevel;
    end else begin
      userOut <= active ? cfg.polarity : ~cfg.polarity;
    end
  end

endmodule

// >>> design/bad_decoder.sv
`timescale 1ns/10ps
// ==========================================================
// banked address decoder with bank and configuration registers
module bad_decoder #(
  parameter int RAM_BANKS = 8
) (
  clk,
  sys_rst,
  busAddr,
  busWrStb,
  busRdStb,
  busWrData,
  busRdData,
  busRdValid,
  ramSel,
  ramAddr,
  netSel,
  netAddr,
  userOutA,
  userOutB
);
  // ==========================================================
  // ports
  input  wire logic                           clk;
  input  wire logic                           sys_rst;
  input  wire logic [bad_pkg::BUS_ADDR_W-1:0] busAddr;
  input  wire logic                           busWrStb;
  input  wire logic                           busRdStb;
  input  wire logic [bad_pkg::BUS_DATA_W-1:0] busWrData;
  output logic      [bad_pkg::BUS_DATA_W-1:0] busRdData;
  output logic                                busRdValid;
  output logic                                ramSel;
  output logic      [bad_pkg::RAM_ADDR_W-1:0] ramAddr;
  output logic                                netSel;
  output logic      [bad_pkg::NET_ADDR_W-1:0] netAddr;
  output logic                                userOutA;
  output logic                                userOutB;

  // ==========================================================
  // local constants
  // the last two banks back the unbanked base area in banking mode
  localparam int                         BASE_BANK_INT  = RAM_BANKS - 2;
  localparam logic [31:0]                BASE_BANK_WIDE = BASE_BANK_INT;
  localparam logic [bad_pkg::BANK_W-1:0] BASE_BANK      = BASE_BANK_WIDE[bad_pkg::BANK_W-1:0];

  // ==========================================================
  // internal signals
  bad_pkg::bad_bus_req_t          busReq;          // host request of this cycle
  logic [bad_pkg::BANK_W-1:0]     bankChoice_reg;  // chosen window bank
  bad_pkg::bad_dec_cfg_t          decConfig_reg;   // map mode and user output setup
  logic                           hitBank;         // access to the bank register
  logic                           hitConf;         // access to the configuration register
  logic                           hitUoA;          // access in the first user output range
  logic                           hitUoB;          // access in the second user output range
  logic                           inLowRam;        // below the 32kB line
  logic                           inWindow;        // inside the banked window
  logic                           inLinear;        // inside the linear RAM span
  logic                           inReserved;      // inside the controller page
  logic                           inNetCompat;     // network area, compatibility mode
  logic                           inNetBanked;     // network area, banking mode
  logic                           inNetLinear;     // network area, linear mode
  logic                           ramSel_next;
  logic [bad_pkg::RAM_ADDR_W-1:0] ramAddr_next;
  logic                           netSel_next;
  logic [bad_pkg::NET_ADDR_W-1:0] netAddr_next;
  logic                           rdValid_next;
  logic [bad_pkg::BUS_DATA_W-1:0] rdData_next;

  // ==========================================================
  // host request carrier
  // bundle the bus pins so the decode reads one record
  assign busReq = {busAddr, busWrStb, busRdStb, busWrData};

  // ==========================================================
  // address compares
  // controller registers sit at the bottom of the reserved page
  assign hitBank = (busReq.addr == bad_pkg::ADDR_BANK_CHOICE);
  assign hitConf = (busReq.addr == bad_pkg::ADDR_DEC_CONFIG);

  // each user output owns an aligned group of four addresses
  assign hitUoA = (busReq.addr[15:2] == bad_pkg::UOA_BASE[15:2]);
  assign hitUoB = (busReq.addr[15:2] == bad_pkg::UOB_BASE[15:2]);

  // RAM spans for the three map modes
  assign inLowRam   = (busReq.addr <= bad_pkg::LOW_RAM_TOP);
  assign inWindow   = (busReq.addr >= bad_pkg::WINDOW_BASE) && (busReq.addr <= bad_pkg::WINDOW_TOP);
  assign inLinear   = (busReq.addr <= bad_pkg::LINEAR_TOP);
  assign inReserved = (busReq.addr >= bad_pkg::RESERVED_BASE);

  // network controller spans for the three map modes
  assign inNetCompat = (busReq.addr >= bad_pkg::NET_M0_BASE) && (busReq.addr <= bad_pkg::NET_M0_TOP);
  assign inNetBanked = (busReq.addr >= bad_pkg::NET_M1_BASE) && (busReq.addr <= bad_pkg::NET_M1_TOP);
  assign inNetLinear = (busReq.addr >= bad_pkg::NET_M2_BASE);

  // ==========================================================
  // memory map decode
  // route the address to RAM or the network controller by map mode;
  // the reserved top page never reaches RAM in any mode
  always_comb begin
    ramSel_next  = 1'b0;
    ramAddr_next = '0;
    netSel_next  = 1'b0;
    netAddr_next = '0;
    unique case (decConfig_reg.mapMode)
      bad_pkg::MAP_COMPAT: begin
        // only the low 32kB, the rest of RAM is out of reach
        if (inLowRam) begin
          ramSel_next  = 1'b1;
          ramAddr_next = {2'b00, busReq.addr};
        end
        if (inNetCompat) begin
          netSel_next  = 1'b1;
          netAddr_next = busReq.addr[11:0];
        end
      end
      bad_pkg::MAP_BANKED: begin
        // base area always shows the last bank pair
        if (inLowRam) begin
          ramSel_next  = 1'b1;
          ramAddr_next = {BASE_BANK[bad_pkg::BANK_W-1:1], busReq.addr[14:0]};
        end
        // the window follows the bank register, only in this mode
        if (inWindow) begin
          ramSel_next  = 1'b1;
          ramAddr_next = {bankChoice_reg, busReq.addr[13:0]};
        end
        if (inNetBanked) begin
          netSel_next  = 1'b1;
          netAddr_next = busReq.addr[11:0];
        end
      end
      bad_pkg::MAP_LINEAR: begin
        // one flat RAM span up to the reserved page
        if (inLinear && !inReserved) begin
          ramSel_next  = 1'b1;
          ramAddr_next = {2'b00, busReq.addr};
        end
        if (inNetLinear) begin
          netSel_next  = 1'b1;
          netAddr_next = {5'h00, busReq.addr[6:0]};
        end
      end
      bad_pkg::MAP_SPARE: begin
        // undefined map code: nothing outside the controller answers
        ramSel_next = 1'b0;
        netSel_next = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // bank choice register
  // only the four low bits exist; the upper data bits are dropped
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      bankChoice_reg <= bad_pkg::BANK_RESET;
    end else if (busReq.wr && hitBank) begin
      bankChoice_reg <= busReq.wrData[bad_pkg::BANK_W-1:0];
    end
  end

  // ==========================================================
  // configuration register
  // write-only; reset leaves compatibility mode with idle outputs
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      decConfig_reg <= bad_pkg::bad_dec_cfg_t'(bad_pkg::CONF_RESET);
    end else if (busReq.wr && hitConf) begin
      decConfig_reg <= bad_pkg::bad_dec_cfg_t'(busReq.wrData);
    end
  end

  // ==========================================================
  // register read port
  // the bank register reads back with zero upper bits; the
  // configuration register has no read path and returns zero
  always_comb begin
    rdValid_next = busReq.rd && (hitBank || hitConf);
    rdData_next  = '0;
    if (busReq.rd && hitBank) begin
      rdData_next = {4'h0, bankChoice_reg};
    end else if (busReq.rd && hitConf) begin
      rdData_next = '0;
    end
  end

  // read data and its valid flag stand for one cycle
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      busRdData  <= '0;
      busRdValid <= 1'b0;
    end else begin
      busRdData  <= rdData_next;
      busRdValid <= rdValid_next;
    end
  end

  // ==========================================================
  // registered map outputs
  // selects and addresses follow the bus address one cycle later
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ramSel  <= 1'b0;
      ramAddr <= '0;
      netSel  <= 1'b0;
      netAddr <= '0;
    end else begin
      ramSel  <= ramSel_next;
      ramAddr <= ramAddr_next;
      netSel  <= netSel_next;
      netAddr <= netAddr_next;
    end
  end

  // ==========================================================
  // user outputs
  // first output: static mode drives its own polarity bit
  bad_user_output outAUnit (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .hit         (hitUoA),
    .wr          (busReq.wr),
    .rd          (busReq.rd),
    .cfg         (decConfig_reg.outA),
    .staticLevel (decConfig_reg.outA.polarity),
    .userOut     (userOutA)
  );

  // second output: static mode follows bank bit 3, the top RAM
  // address bit when the larger memory is fitted
  bad_user_output outBUnit (
    .clk         (clk),
    .sys_rst     (sys_rst),
    .hit         (hitUoB),
    .wr          (busReq.wr),
    .rd          (busReq.rd),
    .cfg         (decConfig_reg.outB),
    .staticLevel (bankChoice_reg[bad_pkg::BANK_W-1]),
    .userOut     (userOutB)
  );

  // ==========================================================
  // assertions

  // compatibility mode shows low RAM at the bus address
  property p_compat_low_ram;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.mapMode == bad_pkg::MAP_COMPAT) && (busAddr <= bad_pkg::LOW_RAM_TOP)
      |=> ramSel && (ramAddr == {2'b00, $past(busAddr)});
  endproperty
  a_compat_low_ram: assert property (p_compat_low_ram)
    else $error("low RAM not selected in compatibility mode");

  // compatibility mode network area
  property p_compat_net;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.mapMode == bad_pkg::MAP_COMPAT) && inNetCompat
      |=> netSel && !ramSel;
  endproperty
  a_compat_net: assert property (p_compat_net)
    else $error("network area not selected in compatibility mode");

  // compatibility mode leaves everything above the network area dark
  property p_compat_high_dark;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.mapMode == bad_pkg::MAP_COMPAT) && (busAddr > bad_pkg::NET_M0_TOP)
      |=> !ramSel && !netSel;
  endproperty
  a_compat_high_dark: assert property (p_compat_high_dark)
    else $error("upper space answered in compatibility mode");

  // banking mode window carries the chosen bank
  property p_window_bank;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.mapMode == bad_pkg::MAP_BANKED) && inWindow
      |=> ramSel && (ramAddr[17:14] == $past(bankChoice_reg));
  endproperty
  a_window_bank: assert property (p_window_bank)
    else $error("window does not follow the bank register");

  // banking mode base area sits in the last bank pair
  property p_base_last_bank;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.mapMode == bad_pkg::MAP_BANKED) && inLowRam
      |=> ramSel && (ramAddr[17:15] == BASE_BANK[bad_pkg::BANK_W-1:1]);
  endproperty
  a_base_last_bank: assert property (p_base_last_bank)
    else $error("base area not backed by the last banks");

  // banking mode network area
  property p_net_banked;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.mapMode == bad_pkg::MAP_BANKED) && inNetBanked
      |=> netSel && !ramSel;
  endproperty
  a_net_banked: assert property (p_net_banked)
    else $error("network area not selected in banking mode");

  // linear mode maps RAM one to one
  property p_linear_ram;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.mapMode == bad_pkg::MAP_LINEAR) && (busAddr <= bad_pkg::LINEAR_TOP)
      |=> ramSel && (ramAddr == {2'b00, $past(busAddr)});
  endproperty
  a_linear_ram: assert property (p_linear_ram)
    else $error("linear RAM address wrong");

  // linear mode network area at the top
  property p_linear_net;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.mapMode == bad_pkg::MAP_LINEAR) && inNetLinear
      |=> netSel && !ramSel;
  endproperty
  a_linear_net: assert property (p_linear_net)
    else $error("network area not selected in linear mode");

  // the controller page never selects RAM
  property p_reserved_no_ram;
    @(posedge clk) disable iff (sys_rst)
      (busAddr >= bad_pkg::RESERVED_BASE)
      |=> !ramSel;
  endproperty
  a_reserved_no_ram: assert property (p_reserved_no_ram)
    else $error("RAM selected inside the controller page");

  // bank register reads back what was stored
  property p_bank_read;
    @(posedge clk) disable iff (sys_rst)
      busRdStb && (busAddr == bad_pkg::ADDR_BANK_CHOICE)
      |=> busRdValid && (busRdData == {4'h0, $past(bankChoice_reg)});
  endproperty
  a_bank_read: assert property (p_bank_read)
    else $error("bank register read back wrong");

  // read data never shows the unimplemented upper bits
  property p_rd_upper_zero;
    @(posedge clk) disable iff (sys_rst)
      busRdValid
      |-> (busRdData[7:4] == 4'h0);
  endproperty
  a_rd_upper_zero: assert property (p_rd_upper_zero)
    else $error("upper read bits not zero");

  // first output in static mode shows its polarity bit
  property p_static_a;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.outA.mode == bad_pkg::UO_STATIC)
      |=> (userOutA == $past(decConfig_reg.outA.polarity));
  endproperty
  a_static_a: assert property (p_static_a)
    else $error("first output static level wrong");

  // second output in static mode shows bank bit 3
  property p_static_b;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.outB.mode == bad_pkg::UO_STATIC)
      |=> (userOutB == $past(bankChoice_reg[bad_pkg::BANK_W-1]));
  endproperty
  a_static_b: assert property (p_static_b)
    else $error("second output does not follow bank bit 3");

  // first output write strobe fires on a write in its range
  property p_strobe_a;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.outA.mode == bad_pkg::UO_WR_STROBE) && busWrStb && hitUoA
      |=> (userOutA == $past(decConfig_reg.outA.polarity));
  endproperty
  a_strobe_a: assert property (p_strobe_a)
    else $error("first output write strobe missing");

  // first output write strobe idles without a bus access
  property p_idle_a;
    @(posedge clk) disable iff (sys_rst)
      (decConfig_reg.outA.mode == bad_pkg::UO_WR_STROBE) && !busWrStb && !busRdStb
      |=> (userOutA == !$past(decConfig_reg.outA.polarity));
  endproperty
  a_idle_a: assert property (p_idle_a)
    else $error("first output not idle");

endmodule

// >>> tb/bad_host_model.sv
`timescale 1ns/10ps
// ===
// host bus master, one access per call
module bad_host_model (
  clk,
  busAddr,
  busWrStb,
  busRdStb,
  busWrData
);
  input  wire logic        clk;
  output logic      [15:0] busAddr = 16'h0000;
  output logic             busWrStb = 1'b0;
  output logic             busRdStb = 1'b0;
  output logic      [7:0]  busWrData = 8'h00;
  // strobe held for one rising edge, then released
  task automatic acc(input logic [15:0] a, input logic w, input logic r, input logic [7:0] d);
    @(negedge clk);
    busAddr = a;
    busWrStb = w;
    busRdStb = r;
    busWrData = d;
    @(negedge clk);
    busWrStb = 1'b0;
    busRdStb = 1'b0;
    busWrData = ~d;
  endtask
endmodule

// >>> tb/bad_decoder_test.sv
`timescale 1ns/10ps
// ===
module bad_decoder_test;
  logic clk = 1'b0, sys_rst = 1'b1, busWrStb, busRdStb, busRdValid, ramSel, netSel, userOutA, userOutB;
  logic [15:0] busAddr;
  logic [7:0] busWrData, busRdData;
  logic [17:0] ramAddr;
  logic [11:0] netAddr;
  int n_mismatch = 0, samples_checked = 0;
  // clock
  initial forever #5 clk = ~clk;
  bad_host_model host (.clk(clk), .busAddr(busAddr), .busWrStb(busWrStb), .busRdStb(busRdStb), .busWrData(busWrData));
  bad_decoder dut (.clk(clk), .sys_rst(sys_rst), .busAddr(busAddr), .busWrStb(busWrStb), .busRdStb(busRdStb),
    .busWrData(busWrData), .busRdData(busRdData), .busRdValid(busRdValid), .ramSel(ramSel), .ramAddr(ramAddr),
    .netSel(netSel), .netAddr(netAddr), .userOutA(userOutA), .userOutB(userOutB));
  // compare and count
  task automatic chk(input string n, input logic [17:0] s, input logic [17:0] e);
    samples_checked++;
    if (s !== e) begin
      n_mismatch++;
      $display("unexpected %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic complete_run;
    $display("mismatches %0d checks %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // bounded wait for read data
  task automatic rd(input logic [15:0] a, output logic [7:0] q);
    int i;
    host.acc(a, 1'b0, 1'b1, 8'h00);
    for (i = 0; i < 8 && busRdValid !== 1'b1; i++) @(negedge clk);
    if (i == 8) begin
      n_mismatch++;
      complete_run();
    end else begin
      q = busRdData;
    end
  endtask
  logic [7:0] q;
  // main sequence
  initial begin
    repeat (2) @(negedge clk);
    sys_rst = 1'b0;
    @(negedge clk);
    chk("outA", {17'h0, userOutA}, 18'h1);
    host.acc(16'hFF01, 1'b1, 1'b0, 8'h00);
    host.acc(16'h1234, 1'b0, 1'b0, 8'h00);
    chk("ram", {ramSel, ramAddr[16:0]}, 18'h21234);
    host.acc(16'h8000, 1'b0, 1'b0, 8'h00);
    chk("net0", {17'h0, netSel}, 18'h1);
    host.acc(16'hFF00, 1'b1, 1'b0, 8'hF3);
    rd(16'hFF00, q);
    chk("bank", {10'h0, q}, 18'h3);
    host.acc(16'hFF01, 1'b1, 1'b0, 8'h01);
    host.acc(16'h8000, 1'b0, 1'b0, 8'h00);
    chk("win", ramAddr, 18'h0C000);
    host.acc(16'h0123, 1'b0, 1'b0, 8'h00);
    chk("base", ramAddr, 18'h18123);
    host.acc(16'hC000, 1'b0, 1'b0, 8'h00);
    chk("net1", {17'h0, netSel}, 18'h1);
    host.acc(16'hFF01, 1'b1, 1'b0, 8'h0E);
    host.acc(16'h8000, 1'b0, 1'b0, 8'h00);
    chk("lin", ramAddr, 18'h08000);
    chk("outA", {17'h0, userOutA}, 18'h0);
    host.acc(16'hFF85, 1'b0, 1'b0, 8'h00);
    chk("net2", {17'h0, netSel}, 18'h1);
    chk("netAddr", {6'h0, netAddr}, 18'h00005);
    chk("outB", {17'h0, userOutB}, 18'h1);
    host.acc(16'hFF01, 1'b1, 1'b0, 8'h12);
    host.acc(16'hFF04, 1'b1, 1'b0, 8'h00);
    chk("outA", {17'h0, userOutA}, 18'h1);
    host.acc(16'hFF01, 1'b1, 1'b0, 8'h6E);
    host.acc(16'hFF00, 1'b1, 1'b0, 8'h08);
    @(negedge clk);
    chk("outB", {17'h0, userOutB}, 18'h1);
    complete_run();
  end
endmodule
